// File: verilog/shc_command_port.sv
// serial-bus slave command port of the hub controller
`timescale 1ns/1ps
`include "shc_cfg.svh"

// Notes on behaviour
// - transfers carry 7-bit address, 16-bit buffer offset, byte count, then data bytes
// - answer only at the slave address: 0101100b or 0101101b as selected, or the one loaded by set address
// - every byte is shifted most significant bit first
// - at most 32 data bytes per block transfer
// - block read uses repeated start and read address after the offset
// - special opcode replaces the offset and ends with one zero byte
// - 9936h reboots the controller, 9937h opens configuration access
// - 993Eh runs the extended command held in the buffer
// - AA55h starts attach; AA56h starts attach keeping bus access
// - codes 00h-03h: set address, default address, hub info, power mask
// - codes 80h-83h port status or disable; 84h-87h power controller
// - the command code is fetched from buffer offset 0000h
// - status byte at 0001h is overwritten with the result when done
// - first data at 0002h, per-port data at 0004h plus index
// - set address loads bits 6:0 of the first data byte, or the default address when bit 7 is set
// - first data byte is a port mask, bit 0 the upstream port
// - connect byte: bit5 usb2 suspend, bit4 usb3 suspend, bit1, bit0
module shc_command_port #(
	parameter int RAM_AW  = 13,
	parameter int N_PORTS = 8
) (
	input  wire logic               clk_sys_in,
	input  wire logic               srst_in,
	input  wire logic               ce_in,
	input  wire logic               serial_bus_clock_in,
	input  wire logic               serial_bus_data_line_in,
	output logic                    serial_bus_data_line_out,
	output logic                    serial_bus_data_line_oe_n_out,
	input  wire logic               addr_sel_in,
	output logic [6:0]              slave_addr_out,
	output logic                    mcu_reboot_out,
	output logic                    cfg_access_out,
	output logic                    usb_attach_out,
	output logic                    smbus_keep_out,
	output logic                    ext_busy_out,
	input  wire logic [N_PORTS-1:0] port_usb2_susp_in,
	input  wire logic [N_PORTS-1:0] port_usb3_susp_in,
	input  wire logic [N_PORTS-1:0] port_usb2_conn_in,
	input  wire logic [N_PORTS-1:0] port_usb3_conn_in,
	input  wire logic [N_PORTS-1:0] port_power_in,
	input  wire logic [N_PORTS-1:0] port_dp_in,
	input  wire logic [N_PORTS-1:0] port_dm_in,
	output logic      [N_PORTS-1:0] port_force_off_out,
	output logic      [N_PORTS-1:0] port_usb3_term_dis_out,
	output logic      [N_PORTS-1:0] port_usb2_term_dis_out,
	input  wire logic [7:0]         hub_info_in,
	input  wire logic [7:0]         ppc_mask_in,
	output logic                    epc_req_out,
	output logic      [1:0]         epc_op_out,
	output logic      [7:0]         epc_data_out,
	input  wire logic               epc_done_in,
	input  wire logic [7:0]         epc_rdata_in,
	input  wire logic [7:0]         epc_status_in
);
	// ****************************************************************
	// pin synchronisers and bus events
	// ****************************************************************
	logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, sel_m, sel_s;
	logic scl_rise, scl_fall, start_ev, stop_ev;

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			{scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3F;
			{sel_m, sel_s} <= 2'h0;
		end else if (ce_in) begin
			{scl_m, scl_s, scl_d} <= {serial_bus_clock_in, scl_m, scl_s};
			{sda_m, sda_s, sda_d} <= {serial_bus_data_line_in, sda_m, sda_s};
			{sel_m, sel_s} <= {addr_sel_in, sel_m};
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

	// ****************************************************************
	// shared signals
	// ****************************************************************
	shc_pkg::shc_phase_t phase_reg;
	shc_pkg::shc_role_t  role_reg;
	shc_pkg::shc_xst_t   xst_reg;
	logic [2:0]  bitcnt_reg, pidx_reg;
	logic [7:0]  shift_reg, tx_reg, left_reg, code_reg, d1_reg, stat_reg;
	logic [15:0] off_reg, op_reg;
	logic [5:0]  ndata_reg;
	logic [6:0]  def_addr_reg, slave_addr_reg;
	logic [1:0]  strap_cnt_reg;
	logic full_reg, rw_reg, ack_reg, oe_n_reg, mack_reg, term_ok_reg;
	logic ack_ok, rx_take, smb_we, exec_go, busy, ram_we;
	logic [7:0] ram_wd, ram_rdata, tx_next;
	logic [RAM_AW-1:0] ram_addr;
	logic [7:0] port_byte [0:N_PORTS-1];

	assign busy = (xst_reg != shc_pkg::X_IDLE);
	assign rx_take = (phase_reg == shc_pkg::P_RX) && full_reg && scl_fall;

	// ****************************************************************
	// slave address selection
	// ****************************************************************
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			strap_cnt_reg  <= 2'h0;
			def_addr_reg   <= `SHC_ADDR_A;
			slave_addr_reg <= `SHC_ADDR_A;
		end else if (ce_in) begin
			if (strap_cnt_reg != 2'h3) begin
				strap_cnt_reg <= strap_cnt_reg + 2'h1;
				if (strap_cnt_reg == 2'h2) begin
					def_addr_reg   <= sel_s ? `SHC_ADDR_B : `SHC_ADDR_A;
					slave_addr_reg <= sel_s ? `SHC_ADDR_B : `SHC_ADDR_A;
				end
			end else if (xst_reg == shc_pkg::X_DEC &&
					code_reg == `SHC_X_SET_ADDR) begin
				slave_addr_reg <= ram_rdata[`SHC_DIS_OVR_BIT] ?
					def_addr_reg : ram_rdata[6:0];
			end
		end
	end

	// ****************************************************************
	// byte acceptance
	// ****************************************************************
	always_comb begin
		ack_ok = 1'b0;
		case (role_reg)
			shc_pkg::R_ADDR: ack_ok = (shift_reg[7:1] == slave_addr_reg)
				&& !busy;
			shc_pkg::R_OFFH: ack_ok = 1'b1;
			shc_pkg::R_OFFL: ack_ok = 1'b1;
			shc_pkg::R_TERM: ack_ok = (shift_reg == 8'h00);
			shc_pkg::R_CNT:  ack_ok = (shift_reg != 8'h00) &&
				(shift_reg <= `SHC_BLK_MAX);
			shc_pkg::R_DATA: ack_ok = (left_reg != 8'h00);
			default:         ack_ok = 1'b0;
		endcase
	end

	assign smb_we = rx_take && (role_reg == shc_pkg::R_DATA) && ack_ok;
	assign tx_next = (ndata_reg < 6'(`SHC_BLK_MAX)) ? ram_rdata
		: `SHC_FILL_BYTE;

	function automatic logic is_special(input logic [15:0] v);
		is_special = (v == `SHC_OP_REBOOT) || (v == `SHC_OP_CFG) ||
			(v == `SHC_OP_EXT) || (v == `SHC_OP_ATTACH) ||
			(v == `SHC_OP_ATTACH_KP);
	endfunction : is_special

	// ****************************************************************
	// serial protocol engine
	// ****************************************************************
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			phase_reg <= shc_pkg::P_IDLE;
			role_reg  <= shc_pkg::R_ADDR;
			{bitcnt_reg, shift_reg, tx_reg, left_reg} <= 27'h0;
			{off_reg, op_reg, ndata_reg} <= 38'h0;
			{full_reg, rw_reg, ack_reg, mack_reg, term_ok_reg} <= 5'h0;
			oe_n_reg <= 1'b1;
		end else if (ce_in) begin
			if (start_ev) begin
				phase_reg   <= shc_pkg::P_RX;
				role_reg    <= shc_pkg::R_ADDR;
				bitcnt_reg  <= 3'h0;
				full_reg    <= 1'b0;
				oe_n_reg    <= 1'b1;
				term_ok_reg <= 1'b0;
			end else if (stop_ev) begin
				phase_reg   <= shc_pkg::P_IDLE;
				oe_n_reg    <= 1'b1;
				term_ok_reg <= 1'b0;
			end else begin
				case (phase_reg)
					shc_pkg::P_RX: begin
						if (scl_rise && !full_reg) begin
							shift_reg  <= {shift_reg[6:0], sda_s};
							bitcnt_reg <= bitcnt_reg + 3'h1;
							full_reg   <= (bitcnt_reg == 3'h7);
						end else if (rx_take) begin
							full_reg  <= 1'b0;
							phase_reg <= shc_pkg::P_RXACK;
							ack_reg   <= ack_ok;
							oe_n_reg  <= !ack_ok;
							case (role_reg)
								shc_pkg::R_ADDR: begin
									rw_reg    <= shift_reg[0];
									ndata_reg <= 6'h0;
								end
								shc_pkg::R_OFFH: off_reg[15:8] <= shift_reg;
								shc_pkg::R_OFFL: begin
									off_reg[7:0] <= shift_reg;
									op_reg <= {off_reg[15:8], shift_reg};
								end
								shc_pkg::R_TERM: term_ok_reg <= ack_ok;
								shc_pkg::R_CNT:  left_reg <= ack_ok ? shift_reg : 8'h00;
								shc_pkg::R_DATA: begin
									if (ack_ok) begin
										off_reg  <= off_reg + 16'h1;
										left_reg <= left_reg - 8'h1;
									end
								end
								default: ;
							endcase
						end
					end
					shc_pkg::P_RXACK: begin
						if (scl_fall) begin
							oe_n_reg   <= 1'b1;
							bitcnt_reg <= 3'h0;
							if (!ack_reg) begin
								phase_reg <= shc_pkg::P_IDLE;
							end else if (role_reg == shc_pkg::R_ADDR && rw_reg) begin
								phase_reg <= shc_pkg::P_TX;
								role_reg  <= shc_pkg::R_CNT;
								tx_reg    <= `SHC_BLK_MAX;
								oe_n_reg  <= 1'(`SHC_BLK_MAX >> 7);
							end else begin
								phase_reg <= shc_pkg::P_RX;
								case (role_reg)
									shc_pkg::R_ADDR: role_reg <= shc_pkg::R_OFFH;
									shc_pkg::R_OFFH: role_reg <= shc_pkg::R_OFFL;
									shc_pkg::R_OFFL: role_reg <= is_special(op_reg) ?
										shc_pkg::R_TERM : shc_pkg::R_CNT;
									shc_pkg::R_CNT:  role_reg <= shc_pkg::R_DATA;
									shc_pkg::R_DATA: role_reg <= shc_pkg::R_DATA;
									default:         role_reg <= shc_pkg::R_DONE;
								endcase
							end
						end
					end
					shc_pkg::P_TX: begin
						if (scl_fall) begin
							if (bitcnt_reg == 3'h7) begin
								oe_n_reg  <= 1'b1;
								phase_reg <= shc_pkg::P_TXACK;
							end else begin
								bitcnt_reg <= bitcnt_reg + 3'h1;
								tx_reg     <= {tx_reg[6:0], 1'b0};
								oe_n_reg   <= tx_reg[6];
							end
						end
					end
					shc_pkg::P_TXACK: begin
						if (scl_rise) begin
							mack_reg <= !sda_s;
							if (sda_s) begin
								phase_reg <= shc_pkg::P_IDLE;
							end
						end else if (scl_fall && mack_reg) begin
							mack_reg   <= 1'b0;
							phase_reg  <= shc_pkg::P_TX;
							bitcnt_reg <= 3'h0;
							tx_reg     <= tx_next;
							oe_n_reg   <= tx_next[7];
							if (ndata_reg < 6'(`SHC_BLK_MAX)) begin
								off_reg   <= off_reg + 16'h1;
								ndata_reg <= ndata_reg + 6'h1;
							end
						end
					end
					default: ;
				endcase
			end
		end
	end

	assign serial_bus_data_line_out      = 1'b0;
	assign serial_bus_data_line_oe_n_out = oe_n_reg;
	assign slave_addr_out                = slave_addr_reg;

	// ****************************************************************
	// special opcode actions
	// ****************************************************************
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			{mcu_reboot_out, cfg_access_out, usb_attach_out} <= 3'h0;
			{exec_go, smbus_keep_out} <= 2'h0;
		end else if (ce_in) begin
			{mcu_reboot_out, cfg_access_out, usb_attach_out} <= 3'h0;
			exec_go <= 1'b0;
			if (stop_ev && term_ok_reg) begin
				case (op_reg)
					`SHC_OP_REBOOT: mcu_reboot_out <= 1'b1;
					`SHC_OP_CFG:    cfg_access_out <= 1'b1;
					`SHC_OP_EXT:    exec_go        <= 1'b1;
					`SHC_OP_ATTACH: usb_attach_out <= 1'b1;
					`SHC_OP_ATTACH_KP: begin
						usb_attach_out <= 1'b1;
						smbus_keep_out <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	// ****************************************************************
	// per-port status bytes and disable controls
	// ****************************************************************
	genvar gp;
	generate
		for (gp = 0; gp < N_PORTS; gp = gp + 1) begin : g_port
			always_comb begin
				case (code_reg)
					`SHC_X_CONNECT: port_byte[gp] = {2'h0, port_usb2_susp_in[gp],
						port_usb3_susp_in[gp], 2'h0, port_usb2_conn_in[gp],
						port_usb3_conn_in[gp]};
					`SHC_X_POWER: port_byte[gp] = {7'h0, port_power_in[gp]};
					default: port_byte[gp] = {6'h0, port_dp_in[gp],
						port_dm_in[gp]};
				endcase
			end
			always_ff @(posedge clk_sys_in) begin
				if (srst_in) begin
					port_force_off_out[gp]     <= 1'b0;
					port_usb3_term_dis_out[gp] <= 1'b0;
					port_usb2_term_dis_out[gp] <= 1'b0;
				end else if (ce_in && xst_reg == shc_pkg::X_PNEXT &&
						code_reg == `SHC_X_DISABLE && pidx_reg == 3'(gp) &&
						d1_reg[gp] && ram_rdata[`SHC_DIS_OVR_BIT]) begin
					port_force_off_out[gp]     <= ram_rdata[2];
					port_usb3_term_dis_out[gp] <= ram_rdata[1];
					port_usb2_term_dis_out[gp] <= ram_rdata[0];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// extended command sequencer
	// ****************************************************************
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			xst_reg <= shc_pkg::X_IDLE;
			{code_reg, d1_reg, stat_reg, pidx_reg} <= 27'h0;
		end else if (ce_in) begin
			case (xst_reg)
				shc_pkg::X_IDLE: if (exec_go) xst_reg <= shc_pkg::X_CODE;
				shc_pkg::X_CODE: xst_reg <= shc_pkg::X_D1;
				shc_pkg::X_D1: begin
					code_reg <= ram_rdata;
					xst_reg  <= shc_pkg::X_DEC;
				end
				shc_pkg::X_DEC: begin
					d1_reg   <= ram_rdata;
					stat_reg <= `SHC_STAT_OK;
					pidx_reg <= 3'h0;
					if (code_reg <= `SHC_X_PPC_MASK) begin
						xst_reg <= shc_pkg::X_STAT;
					end else if (code_reg >= `SHC_X_CONNECT &&
							code_reg <= `SHC_X_DPDM) begin
						xst_reg <= shc_pkg::X_PORT;
					end else if (code_reg >= `SHC_X_EPC_FIRST &&
							code_reg <= `SHC_X_EPC_LAST) begin
						xst_reg <= shc_pkg::X_EPC;
					end else begin
						stat_reg <= `SHC_STAT_ERR;
						xst_reg  <= shc_pkg::X_STAT;
					end
				end
				shc_pkg::X_PORT: xst_reg <= shc_pkg::X_PNEXT;
				shc_pkg::X_PNEXT: begin
					if (pidx_reg == 3'(N_PORTS - 1)) begin
						xst_reg <= shc_pkg::X_STAT;
					end else begin
						pidx_reg <= pidx_reg + 3'h1;
						xst_reg  <= shc_pkg::X_PORT;
					end
				end
				shc_pkg::X_EPC: begin
					if (epc_done_in) begin
						stat_reg <= epc_status_in;
						xst_reg  <= shc_pkg::X_STAT;
					end
				end
				default: xst_reg <= shc_pkg::X_IDLE;
			endcase
		end
	end

	always_comb begin
		ram_addr = off_reg[RAM_AW-1:0];
		ram_we   = smb_we;
		ram_wd   = shift_reg;
		case (xst_reg)
			shc_pkg::X_IDLE: ;
			shc_pkg::X_CODE: begin
				ram_addr = RAM_AW'(`SHC_OFF_CODE);
				ram_we   = 1'b0;
			end
			shc_pkg::X_DEC: begin
				ram_addr = RAM_AW'(`SHC_OFF_COMMAND_FIRST_DATA);
				ram_we   = (code_reg == `SHC_X_DEF_ADDR) ||
					(code_reg == `SHC_X_HUB_INFO) || (code_reg == `SHC_X_PPC_MASK);
				ram_wd   = (code_reg == `SHC_X_DEF_ADDR) ? {1'b0, def_addr_reg}
					: (code_reg == `SHC_X_HUB_INFO) ? hub_info_in : ppc_mask_in;
			end
			shc_pkg::X_PORT, shc_pkg::X_PNEXT: begin
				ram_addr = RAM_AW'(`SHC_OFF_COMMAND_NTH_DATA + {13'h0, pidx_reg});
				ram_we   = (xst_reg == shc_pkg::X_PORT) && d1_reg[pidx_reg] &&
					(code_reg != `SHC_X_DISABLE);
				ram_wd   = port_byte[pidx_reg];
			end
			shc_pkg::X_EPC: begin
				ram_addr = RAM_AW'(`SHC_OFF_COMMAND_FIRST_DATA);
				ram_we   = epc_done_in && !code_reg[0];
				ram_wd   = epc_rdata_in;
			end
			shc_pkg::X_STAT: begin
				ram_addr = RAM_AW'(`SHC_OFF_STATUS);
				ram_we   = 1'b1;
				ram_wd   = stat_reg;
			end
			default: begin
				ram_addr = RAM_AW'(`SHC_OFF_COMMAND_FIRST_DATA);
				ram_we   = 1'b0;
			end
		endcase
	end

	assign ext_busy_out = busy;
	assign epc_req_out  = (xst_reg == shc_pkg::X_EPC);
	assign epc_op_out   = code_reg[1:0];
	assign epc_data_out = d1_reg;

	shc_ram #(.AW(RAM_AW)) u_ram (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.ce_in      (ce_in),
		.we_in      (ram_we),
		.addr_in    (ram_addr),
		.wdata_in   (ram_wd),
		.rdata_out  (ram_rdata)
	);

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in || !ce_in);

	sequence s_exec_fetch;
		xst_reg == shc_pkg::X_CODE ##1 xst_reg == shc_pkg::X_D1
			##1 xst_reg == shc_pkg::X_DEC;
	endsequence

	a_addr_ack_match: assert property (
		phase_reg == shc_pkg::P_RXACK && role_reg == shc_pkg::R_ADDR &&
		!oe_n_reg |-> shift_reg[7:1] == slave_addr_reg)
		else $error("address acknowledged without match");
	a_tx_msb_first: assert property (
		phase_reg == shc_pkg::P_TX && scl_fall && bitcnt_reg != 3'h7
		|=> oe_n_reg == $past(tx_reg[6]))
		else $error("transmit bit order wrong");
	a_term_byte_zero: assert property (
		phase_reg == shc_pkg::P_RXACK && role_reg == shc_pkg::R_TERM &&
		!oe_n_reg |-> shift_reg == 8'h00)
		else $error("nonzero terminator acknowledged");
	a_reboot_after_stop: assert property (
		$rose(mcu_reboot_out) |-> $past(stop_ev) &&
		$past(op_reg) == `SHC_OP_REBOOT)
		else $error("reboot not tied to stop and opcode");
	a_exec_fetch_code: assert property (
		exec_go && xst_reg == shc_pkg::X_IDLE |=> s_exec_fetch)
		else $error("extended command fetch sequence broken");
	a_attach_keep_bus: assert property (
		$rose(smbus_keep_out) |-> usb_attach_out)
		else $error("keep-access without attach");
	a_status_written: assert property (
		xst_reg == shc_pkg::X_STAT |-> ram_we &&
		ram_addr == RAM_AW'(`SHC_OFF_STATUS) ##1 xst_reg == shc_pkg::X_IDLE)
		else $error("result status not written");
	a_set_addr_new: assert property (
		xst_reg == shc_pkg::X_DEC && code_reg == `SHC_X_SET_ADDR &&
		!ram_rdata[7] |=> slave_addr_reg == $past(ram_rdata[6:0]))
		else $error("slave address not replaced");
	a_blk_limit: assert property (
		ndata_reg <= 6'(`SHC_BLK_MAX) && left_reg <= `SHC_BLK_MAX)
		else $error("block exceeds 32 bytes");
	a_port_data_slot: assert property (
		xst_reg == shc_pkg::X_PORT && ram_we |-> d1_reg[pidx_reg] &&
		ram_addr == RAM_AW'(`SHC_OFF_COMMAND_NTH_DATA + {13'h0, pidx_reg}))
		else $error("port result in wrong slot");
endmodule : shc_command_port

// File: verilog/shc_cfg.svh
// constants of the serial-bus hub command port
`ifndef SHC_CFG_SVH
`define SHC_CFG_SVH

// ****************************************************************
// slave addresses
// ****************************************************************
`define SHC_ADDR_A       7'h2C
`define SHC_ADDR_B       7'h2D

// ****************************************************************
// special opcodes
// ****************************************************************
`define SHC_OP_REBOOT    16'h9936
`define SHC_OP_CFG       16'h9937
`define SHC_OP_EXT       16'h993E
`define SHC_OP_ATTACH    16'hAA55
`define SHC_OP_ATTACH_KP 16'hAA56

// ****************************************************************
// extended command codes
// ****************************************************************
`define SHC_X_SET_ADDR   8'h00
`define SHC_X_DEF_ADDR   8'h01
`define SHC_X_HUB_INFO   8'h02
`define SHC_X_PPC_MASK   8'h03
`define SHC_X_CONNECT    8'h80
`define SHC_X_POWER      8'h81
`define SHC_X_DISABLE    8'h82
`define SHC_X_DPDM       8'h83
`define SHC_X_EPC_FIRST  8'h84
`define SHC_X_EPC_LAST   8'h87

// ****************************************************************
// buffer layout, limits, result codes
// ****************************************************************
`define SHC_OFF_CODE     16'h0000
`define SHC_OFF_STATUS   16'h0001
`define SHC_OFF_COMMAND_FIRST_DATA    16'h0002
`define SHC_OFF_COMMAND_NTH_DATA    16'h0004
`define SHC_BLK_MAX      8'h20
`define SHC_FILL_BYTE    8'hFF
`define SHC_STAT_OK      8'h01
`define SHC_STAT_ERR     8'h02
`define SHC_DIS_OVR_BIT  7

`endif

// File: verilog/shc_pkg.sv
// types of the serial-bus hub command port
package shc_pkg;
	typedef enum logic [2:0] {
		P_IDLE, P_RX, P_RXACK, P_TX, P_TXACK
	} shc_phase_t;
	typedef enum logic [2:0] {
		R_ADDR, R_OFFH, R_OFFL, R_CNT, R_DATA, R_TERM, R_DONE
	} shc_role_t;
	typedef enum logic [2:0] {
		X_IDLE, X_CODE, X_D1, X_DEC, X_PORT, X_PNEXT, X_EPC, X_STAT
	} shc_xst_t;
endpackage : shc_pkg

// File: verilog/shc_ram.sv
// byte-wide buffer memory with registered read
`timescale 1ns/1ps
module shc_ram #(
	parameter int AW = 13
) (
	input  wire logic          clk_sys_in,
	input  wire logic          srst_in,
	input  wire logic          ce_in,
	input  wire logic          we_in,
	input  wire logic [AW-1:0] addr_in,
	input  wire logic [7:0]    wdata_in,
	output logic      [7:0]    rdata_out
);
	logic [7:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk_sys_in) begin
		if (ce_in && we_in) begin
			mem[addr_in] <= wdata_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			rdata_out <= 8'h00;
		end else if (ce_in) begin
			rdata_out <= mem[addr_in];
		end
	end
endmodule : shc_ram

// File: tb/shc_host_model.sv
// serial-bus host model: drives clock and open-drain data
`timescale 1ns/1ps
module shc_host_model (
	output logic      scl_out,
	output logic      sda_oe_n_out,
	input  wire logic sda_in
);
	initial begin
		scl_out = 1'b1;
		sda_oe_n_out = 1'b1;
	end
	// one bit slot of 320 ns: low 240, high 80
	task automatic slot(input logic v, output logic s);
		#80 sda_oe_n_out = v;
		#160 scl_out = 1'b1;
		s = sda_in;
		#80 scl_out = 1'b0;
	endtask : slot
	// start or repeated start
	task automatic start_c();
		#160 sda_oe_n_out = 1'b1;
		#160 scl_out = 1'b1;
		#160 sda_oe_n_out = 1'b0;
		#160 scl_out = 1'b0;
	endtask : start_c
	task automatic stop_c();
		#80 sda_oe_n_out = 1'b0;
		#80 scl_out = 1'b1;
		#160 sda_oe_n_out = 1'b1;
		#160;
	endtask : stop_c
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) slot(b[i], s);
		slot(1'b1, s);
		ack = ~s;
	endtask : wr_byte
	task automatic rd_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			slot(1'b1, s);
			b[i] = s;
		end
		slot(last, s);
	endtask : rd_byte
endmodule : shc_host_model

// File: tb/shc_command_port_bench.sv
// self-checking bench of the serial-bus hub command port
`timescale 1ns/1ps
module shc_command_port_bench;
	typedef struct packed {
		logic [7:0] code, d1, w4, st, e2, e4;
	} shc_row_t;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       scl, h_oe_n, d_oe_n, ok, keep, busy, ereq, edone = 1'b0;
	logic       sel = 1'b1;
	logic [1:0] eop;
	logic [2:0] p;
	logic [7:0] fo, t3, t2, edat, rb[0:32], wb[0:32];
	logic [7:0] pin[9] = '{8'h01, 8'h02, 8'h01, 8'h03, 8'h01, 8'h01,
		8'h00, 8'h5C, 8'hA3};
	logic [6:0] saddr, adr = 7'h2D;
	logic [15:0] ops[4] = '{16'h9936, 16'h9937, 16'hAA55, 16'hAA56};
	int         n_errors = 0, n_checks = 0, cyc = 0, np[3];
	wire        sda = h_oe_n & d_oe_n;
	shc_row_t   rows[12] = '{
		'{8'h01, 8'h00, 8'h00, 8'h01, 8'h2D, 8'h00},
		'{8'h02, 8'h00, 8'h00, 8'h01, 8'h5C, 8'h00},
		'{8'h03, 8'h00, 8'h00, 8'h01, 8'hA3, 8'h00},
		'{8'h80, 8'h01, 8'h00, 8'h01, 8'h01, 8'h23},
		'{8'h81, 8'h01, 8'h00, 8'h01, 8'h01, 8'h01},
		'{8'h83, 8'h01, 8'h00, 8'h01, 8'h01, 8'h02},
		'{8'h82, 8'h01, 8'h85, 8'h01, 8'h01, 8'h85},
		'{8'h55, 8'h33, 8'h00, 8'h02, 8'h33, 8'h00},
		'{8'h84, 8'h11, 8'h00, 8'h07, 8'h6B, 8'h00},
		'{8'h85, 8'h22, 8'h00, 8'h07, 8'h22, 8'h00},
		'{8'h86, 8'h11, 8'h00, 8'h07, 8'h6B, 8'h00},
		'{8'h87, 8'h22, 8'h00, 8'h07, 8'h22, 8'h00}};
	shc_host_model host_u (.scl_out(scl), .sda_oe_n_out(h_oe_n),
		.sda_in(sda));
	shc_command_port #(.RAM_AW(8)) dut_u (.clk_sys_in(clk),
		.srst_in(rst), .ce_in(1'b1), .serial_bus_clock_in(scl),
		.serial_bus_data_line_in(sda), .serial_bus_data_line_out(),
		.serial_bus_data_line_oe_n_out(d_oe_n), .addr_sel_in(sel),
		.slave_addr_out(saddr), .mcu_reboot_out(p[0]),
		.cfg_access_out(p[1]), .usb_attach_out(p[2]),
		.smbus_keep_out(keep), .ext_busy_out(busy),
		.port_usb2_susp_in(pin[0]), .port_usb3_susp_in(pin[1]),
		.port_usb2_conn_in(pin[2]), .port_usb3_conn_in(pin[3]),
		.port_power_in(pin[4]), .port_dp_in(pin[5]), .port_dm_in(pin[6]),
		.port_force_off_out(fo), .port_usb3_term_dis_out(t3),
		.port_usb2_term_dis_out(t2), .hub_info_in(pin[7]),
		.ppc_mask_in(pin[8]), .epc_req_out(ereq), .epc_op_out(eop),
		.epc_data_out(edat), .epc_done_in(edone),
		.epc_rdata_in(8'h6B), .epc_status_in(8'h07));
	always #20 clk = ~clk;
	// power-controller responder and pulse counters
	always @(posedge clk) begin
		#2 edone = (ereq === 1'b1) && !edone;
		cyc++;
		for (int i = 0; i < 3; i++) np[i] += int'(p[i] === 1'b1);
		if (cyc == 60000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [15:0] off,
		input logic [7:0] cnt, input int n);
		logic k;
		logic [23:0] h;
		@(posedge clk);
		#2;
		h = {off, cnt};
		host_u.start_c();
		host_u.wr_byte({a, 1'b0}, ok);
		for (int i = 0; i < n + 3; i++) begin
			host_u.wr_byte(i < 3 ? h[23-8*i -: 8] : wb[i-3], k);
			ok &= k;
		end
		host_u.stop_c();
	endtask : wr
	task automatic rd(input logic [15:0] off, input int n);
		logic k;
		@(posedge clk);
		#2;
		host_u.start_c();
		host_u.wr_byte({adr, 1'b0}, k);
		host_u.wr_byte(off[15:8], k);
		host_u.wr_byte(off[7:0], k);
		host_u.start_c();
		host_u.wr_byte({adr, 1'b1}, k);
		host_u.rd_byte(1'b0, rb[0]);
		for (int i = 1; i <= n; i++) host_u.rd_byte(i == n, rb[i]);
		host_u.stop_c();
	endtask : rd
	task automatic ext(input logic [7:0] code, d1, w4);
		{wb[0], wb[1], wb[2], wb[3], wb[4]} = {code, 8'h00, d1, 8'h00, w4};
		wr(adr, 16'h0000, 8'h05, 5);
		wr(adr, 16'h993E, 8'h00, 0);
		repeat (4) @(posedge clk);
		#2;
		for (int i = 0; i < 400 && busy === 1'b1; i++) #40;
		rd(16'h0000, 5);
	endtask : ext
	task automatic give_verdict();
		if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (16) @(posedge clk);
		#2 rst = 1'b0;
		chk({d_oe_n, saddr}, 8'hAC);
		repeat (6) @(posedge clk);
		chk({1'b0, saddr}, 8'h2D);
		foreach (rows[r]) begin
			ext(rows[r].code, rows[r].d1, rows[r].w4);
			chk(rb[2], rows[r].st);
			chk(rb[3], rows[r].e2);
			chk(rb[5], rows[r].e4);
		end
		chk({5'h0, fo[0], t3[0], t2[0]}, 8'h05);
		chk(edat, 8'h22);
		chk({6'h0, eop}, 8'h03);
		for (int i = 0; i < 32; i++) wb[i] = 8'hA5 ^ 8'(i);
		wr(adr, 16'h0040, 8'h20, 32);
		chk({7'h0, ok}, 8'h01);
		rd(16'h0040, 32);
		chk(rb[0], 8'h20);
		for (int i = 1; i <= 32; i++) chk(rb[i], wb[i-1]);
		wr(adr, 16'h0040, 8'h00, 0);
		chk({7'h0, ok}, 8'h00);
		wr(adr, 16'h0040, 8'h21, 1);
		chk({7'h0, ok}, 8'h00);
		wr(7'h2C, 16'h0040, 8'h01, 1);
		chk({7'h0, ok}, 8'h00);
		ext(8'h00, 8'h11, 8'h00);
		chk({1'b0, saddr}, 8'h11);
		wr(adr, 16'h0040, 8'h01, 1);
		chk({7'h0, ok}, 8'h00);
		adr = 7'h11;
		ext(8'h00, 8'h80, 8'h00);
		chk({1'b0, saddr}, 8'h2D);
		adr = 7'h2D;
		wr(adr, 16'h9936, 8'h01, 0);
		repeat (8) @(posedge clk);
		chk({7'h0, ok}, 8'h00);
		chk(8'(np[0]), 8'h00);
		foreach (ops[i]) begin
			wr(adr, ops[i], 8'h00, 0);
			repeat (8) @(posedge clk);
		end
		chk(8'(np[0]), 8'h01);
		chk(8'(np[1]), 8'h01);
		chk(8'(np[2]), 8'h02);
		chk({7'h0, keep}, 8'h01);
		#2 rst = 1'b1;
		sel = 1'b0;
		repeat (2) @(posedge clk);
		#2 rst = 1'b0;
		chk({d_oe_n, saddr}, 8'hAC);
		repeat (6) @(posedge clk);
		chk({1'b0, saddr}, 8'h2C);
		chk({7'h0, keep}, 8'h00);
		wr(7'h2C, 16'h0040, 8'h01, 1);
		chk({7'h0, ok}, 8'h01);
		give_verdict();
	end
endmodule : shc_command_port_bench
